// [rtl/mcs_config_status.sv]
`timescale 1ns/1ps
`default_nettype none

// Function
// - Run bit high: monitor and drive PWM from programmed limit duty.
// - Run bit low: stop, use default limits, keep programmed values stored.
// - Run bit stays writable after freeze.
// - Monitoring stopped: all PWM outputs at full duty.
// - Freeze bit set by writing 1; cannot be cleared until power cycle.
// - Frozen: writes to lockable registers, max duty included, ignored.
// - Current-sense, bus timeout enable and freeze bits are lockable.
// - Ready bit read-only, set once powered up; writes ignored.
// - Full fan override drives max duty; resets 0, never locked.
// - Current-sense flag is plain storage for software.
// - Spin-up bypass: no end after two speed pulses; run full timeout.
// - Bus timeout enabled: release bus after 35 ms idle in transaction.
// - Flags latch; read clears only if condition has gone.
// - Bit 0: 2.5 V window, or overtemp timer limit in that mode.
// - Bits 1-3: core, supply and 5 V voltage limits.
// - Bits 4-6: remote one, local, remote two temperature limits.
// - Bit 7 is the OR of the secondary status register.
// - Summary mask bit gates secondary alerts onto the alert line.
// - Max duty registers 0x38-0x3A, default full duty.
module mcs_config_status #(
    parameter int NUM_PWM        = 3,
    parameter int TIMEOUT_CYCLES = mcs_pkg::BUS_TIMEOUT_CYCLES,
    parameter int SPINUP_CYCLES  = mcs_pkg::SPINUP_TIMEOUT_CYCLES
) (
    input  wire  logic                        core_clk_i,
    input  wire  logic                        srst_i,
    input  wire  logic [7:0]                  reg_addr_i,
    input  wire  logic                        reg_wr_i,
    input  wire  logic [7:0]                  reg_wdata_i,
    input  wire  logic                        reg_rd_i,
    output var   logic [7:0]                  reg_rdata_o,
    input  wire  logic                        smb_txn_active_i,
    input  wire  logic                        smb_activity_i,
    output var   logic                        bus_release_o,
    input  wire  logic [mcs_pkg::FLG_COND_WIDTH-1:0] limit_cond_i,
    input  wire  logic                        overtemp_mode_i,
    input  wire  logic                        overtemp_timer_cond_i,
    input  wire  logic [7:0]                  secondary_status_i,
    input  wire  logic [7:0]                  primary_mask_i,
    output var   logic                        smb_alert_o,
    input  wire  logic [NUM_PWM-1:0][7:0]     limit_duty_i,
    input  wire  logic [NUM_PWM-1:0]          spinup_start_i,
    input  wire  logic [NUM_PWM-1:0]          fan_speed_pulse_i,
    output var   logic [NUM_PWM-1:0][7:0]     pwm_duty_o,
    output var   logic [NUM_PWM-1:0]          spinup_active_o,
    output var   logic                        monitor_run_o,
    output var   logic                        use_default_limits_o,
    output var   logic                        current_sense_flag_o
);

    // Read index is two bits wide, so at most three outputs
    if (NUM_PWM < 1 || NUM_PWM > 3) begin : g_bad_pwm
        $error("NUM_PWM must be 1 to 3");
    end
    if (TIMEOUT_CYCLES < 2 || SPINUP_CYCLES < 2) begin : g_bad_cnt
        $error("Timeout counts must be at least 2");
    end

    // =====================================================================
    // Configuration register
    logic monitor_run;
    logic freeze;
    logic ready;
    logic full_fan_override;
    logic current_sense_flag;
    logic spinup_detect_bypass;
    logic bus_timeout_enable;
    logic wr_cfg;

    assign wr_cfg = reg_wr_i && (reg_addr_i == mcs_pkg::PRIMARY_CONFIG_OFS);

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            monitor_run          <= mcs_pkg::PRIMARY_CONFIG_RST[0];
            full_fan_override    <= mcs_pkg::PRIMARY_CONFIG_RST[3];
            spinup_detect_bypass <= mcs_pkg::PRIMARY_CONFIG_RST[5];
        end else if (wr_cfg) begin
            // Never locked: stays usable after freeze
            monitor_run <= reg_wdata_i[mcs_pkg::CFG_MONITOR_RUN_BIT];
            full_fan_override <=
                reg_wdata_i[mcs_pkg::CFG_FULL_FAN_BIT];
            spinup_detect_bypass <=
                reg_wdata_i[mcs_pkg::CFG_SPINUP_BYPASS_BIT];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            freeze             <= mcs_pkg::PRIMARY_CONFIG_RST[1];
            current_sense_flag <= mcs_pkg::PRIMARY_CONFIG_RST[4];
            bus_timeout_enable <= mcs_pkg::PRIMARY_CONFIG_RST[6];
        end else if (wr_cfg && !freeze) begin
            freeze <= reg_wdata_i[mcs_pkg::CFG_FREEZE_BIT];
            current_sense_flag <=
                reg_wdata_i[mcs_pkg::CFG_CURRENT_SENSE_BIT];
            bus_timeout_enable <= reg_wdata_i[mcs_pkg::CFG_BUS_TIMEOUT_BIT];
        end
    end

    // Ready comes up with the core; host writes never reach it
    always_ff @(posedge core_clk_i) begin
        if (srst_i)
            ready <= mcs_pkg::PRIMARY_CONFIG_RST[2];
        else
            ready <= 1'b1;
    end

    // =====================================================================
    // Maximum duty registers
    logic [NUM_PWM-1:0][7:0] max_duty;

    generate
        for (genvar g = 0; g < NUM_PWM; g++) begin : g_max
            always_ff @(posedge core_clk_i) begin
                if (srst_i)
                    max_duty[g] <= mcs_pkg::MAX_DUTY_RST;
                else if (reg_wr_i && !freeze && reg_addr_i ==
                         mcs_pkg::MAX_DUTY_BASE_OFS + 8'(g))
                    max_duty[g] <= reg_wdata_i;
            end
        end
    endgenerate

    // =====================================================================
    // Fan spin-up and PWM drive
    logic [NUM_PWM-1:0] pulse_s1;
    logic [NUM_PWM-1:0] pulse_s2;
    logic [NUM_PWM-1:0] pulse_s3;
    logic [NUM_PWM-1:0] spinup;

    // Pin is asynchronous: two flops before any logic reads it
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            pulse_s1 <= '0;
            pulse_s2 <= '0;
            pulse_s3 <= '0;
        end else begin
            pulse_s1 <= fan_speed_pulse_i;
            pulse_s2 <= pulse_s1;
            pulse_s3 <= pulse_s2;
        end
    end

    generate
        for (genvar g = 0; g < NUM_PWM; g++) begin : g_fan
            logic [$clog2(SPINUP_CYCLES+1)-1:0] spin_cnt;
            logic [1:0]                         pulse_cnt;
            logic                               pulse_rise;

            assign pulse_rise = pulse_s2[g] && !pulse_s3[g];

            always_ff @(posedge core_clk_i) begin
                if (srst_i) begin
                    spinup[g] <= 1'b0;
                    spin_cnt  <= '0;
                    pulse_cnt <= '0;
                end else if (spinup_start_i[g]) begin
                    spinup[g] <= 1'b1;
                    spin_cnt  <= '0;
                    pulse_cnt <= '0;
                end else if (spinup[g]) begin
                    spin_cnt <= spin_cnt + 1'b1;
                    if (pulse_rise)
                        pulse_cnt <= pulse_cnt + 1'b1;
                    // Bypass ignores pulses so a noisy fan cannot cut it short
                    if (spin_cnt == ($bits(spin_cnt))'(SPINUP_CYCLES - 1))
                        spinup[g] <= 1'b0;
                    else if (!spinup_detect_bypass && pulse_rise &&
                             pulse_cnt == 2'(mcs_pkg::SPINUP_FAN_SPEED_PULSE_PULSES - 1))
                        spinup[g] <= 1'b0;
                end
            end

            always_ff @(posedge core_clk_i) begin
                if (srst_i)
                    pwm_duty_o[g] <= mcs_pkg::FULL_DUTY;
                else if (!monitor_run || spinup[g])
                    pwm_duty_o[g] <= mcs_pkg::FULL_DUTY;
                else if (full_fan_override)
                    pwm_duty_o[g] <= max_duty[g];
                else
                    pwm_duty_o[g] <= limit_duty_i[g];
            end
        end
    endgenerate

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            spinup_active_o      <= '0;
            monitor_run_o        <= 1'b0;
            use_default_limits_o <= 1'b1;
            current_sense_flag_o <= 1'b0;
        end else begin
            spinup_active_o      <= spinup;
            monitor_run_o        <= monitor_run;
            // Stored limits untouched; only the selection changes
            use_default_limits_o <= !monitor_run;
            current_sense_flag_o <= current_sense_flag;
        end
    end

    // =====================================================================
    // Interrupt flags
    logic [mcs_pkg::FLG_COND_WIDTH-1:0] cond;
    logic [mcs_pkg::FLG_COND_WIDTH-1:0] flags;
    logic [mcs_pkg::FLG_COND_WIDTH-1:0] clr_mask;
    logic                               summary;
    logic                               rd_flags;

    always_comb begin
        cond = limit_cond_i;
        cond[0] = overtemp_mode_i ? overtemp_timer_cond_i
                                  : limit_cond_i[0];
    end

    assign summary  = |secondary_status_i;
    assign rd_flags = reg_rd_i && (reg_addr_i == mcs_pkg::PRIMARY_FLAGS_OFS);
    // Only bits returned as 1 with their condition gone may clear
    assign clr_mask = rd_flags ? (flags & ~cond) : '0;

    always_ff @(posedge core_clk_i) begin
        if (srst_i)
            flags <= mcs_pkg::PRIMARY_FLAGS_RST[6:0];
        else
            flags <= cond | (flags & ~clr_mask);
    end

    // Secondary alerts reach the line only through the summary bit
    always_ff @(posedge core_clk_i) begin
        if (srst_i)
            smb_alert_o <= 1'b0;
        else
            smb_alert_o <= |({summary, flags} & ~primary_mask_i);
    end

    // =====================================================================
    // Read data
    always_ff @(posedge core_clk_i) begin
        if (srst_i)
            reg_rdata_o <= 8'h00;
        else if (reg_rd_i) begin
            if (reg_addr_i == mcs_pkg::PRIMARY_CONFIG_OFS)
                reg_rdata_o <= {1'b0, bus_timeout_enable,
                                spinup_detect_bypass, current_sense_flag,
                                full_fan_override, ready, freeze,
                                monitor_run};
            else if (rd_flags)
                reg_rdata_o <= {summary, flags};
            else if (reg_addr_i >= mcs_pkg::MAX_DUTY_BASE_OFS &&
                     reg_addr_i < mcs_pkg::MAX_DUTY_BASE_OFS + 8'(NUM_PWM))
                reg_rdata_o <= max_duty[2'(reg_addr_i -
                                          mcs_pkg::MAX_DUTY_BASE_OFS)];
            else
                reg_rdata_o <= 8'h00;
        end
    end

    // =====================================================================
    // Bus timeout
    logic [$clog2(TIMEOUT_CYCLES+1)-1:0] idle_cnt;

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            idle_cnt      <= '0;
            bus_release_o <= 1'b0;
        end else if (!bus_timeout_enable || !smb_txn_active_i ||
                     smb_activity_i) begin
            idle_cnt      <= '0;
            bus_release_o <= 1'b0;
        end else if (idle_cnt == ($bits(idle_cnt))'(TIMEOUT_CYCLES)) begin
            // Past the limit: let go as if the bus were stuck
            idle_cnt      <= '0;
            bus_release_o <= 1'b1;
        end else begin
            idle_cnt      <= idle_cnt + 1'b1;
            bus_release_o <= 1'b0;
        end
    end

    // =====================================================================
    // Assertions
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    property p_stop_full_duty;
        !monitor_run |=> pwm_duty_o[0] == mcs_pkg::FULL_DUTY;
    endproperty
    a_stop_full_duty: assert property (p_stop_full_duty)
        else $error("Stopped monitor did not drive full duty");

    property p_override_max;
        monitor_run && full_fan_override && !spinup[0]
            |=> pwm_duty_o[0] == $past(max_duty[0]);
    endproperty
    a_override_max: assert property (p_override_max)
        else $error("Override did not use max duty");

    property p_frozen_hold;
        freeze && reg_wr_i && reg_addr_i == mcs_pkg::MAX_DUTY_BASE_OFS
            |=> $stable(max_duty[0]);
    endproperty
    a_frozen_hold: assert property (p_frozen_hold)
        else $error("Frozen max duty changed");

    property p_run_writable;
        wr_cfg |=> monitor_run == $past(reg_wdata_i[0]);
    endproperty
    a_run_writable: assert property (p_run_writable)
        else $error("Run bit write not taken");

    property p_freeze_sticky;
        freeze |=> freeze [*8];
    endproperty
    a_freeze_sticky: assert property (p_freeze_sticky)
        else $error("Freeze bit cleared");

    property p_flag_kept;
        cond[1] |=> flags[1];
    endproperty
    a_flag_kept: assert property (p_flag_kept)
        else $error("Flag lost while condition present");

    property p_flag_clears;
        rd_flags && flags[2] && !cond[2] |=> !flags[2];
    endproperty
    a_flag_clears: assert property (p_flag_clears)
        else $error("Flag not cleared by read");

    property p_summary;
        rd_flags |=> reg_rdata_o[7] == $past(summary);
    endproperty
    a_summary: assert property (p_summary)
        else $error("Summary bit wrong");

    property p_alert;
        (|secondary_status_i) && !primary_mask_i[7] |=> smb_alert_o;
    endproperty
    a_alert: assert property (p_alert)
        else $error("Unmasked summary did not alert");

    property p_release;
        bus_timeout_enable && smb_txn_active_i && !smb_activity_i &&
        idle_cnt == ($bits(idle_cnt))'(TIMEOUT_CYCLES) |=> bus_release_o;
    endproperty
    a_release: assert property (p_release)
        else $error("Bus not released after timeout");

    c_freeze: cover property (wr_cfg && reg_wdata_i[1] ##1 freeze);
    c_clear_read: cover property (rd_flags && |flags ##1 flags == '0);
    c_release: cover property (bus_release_o);
    c_spinup_done: cover property (spinup[0] ##1 !spinup[0]);

endmodule

`default_nettype wire

// [rtl/mcs_pkg.sv]
package mcs_pkg;

    // =====================================================================
    // Register offsets
    localparam logic [7:0] MAX_DUTY_BASE_OFS   = 8'h38;
    localparam logic [7:0] PRIMARY_CONFIG_OFS  = 8'h40;
    localparam logic [7:0] PRIMARY_FLAGS_OFS   = 8'h41;

    // =====================================================================
    // Primary configuration fields
    localparam int CFG_MONITOR_RUN_BIT   = 0;
    localparam int CFG_FREEZE_BIT        = 1;
    localparam int CFG_READY_BIT         = 2;
    localparam int CFG_FULL_FAN_BIT      = 3;
    localparam int CFG_CURRENT_SENSE_BIT = 4;
    localparam int CFG_SPINUP_BYPASS_BIT = 5;
    localparam int CFG_BUS_TIMEOUT_BIT   = 6;

    // =====================================================================
    // Primary interrupt flag fields
    localparam int FLG_VOLT_WIDTH  = 4;
    localparam int FLG_COND_WIDTH  = 7;
    localparam int FLG_SUMMARY_BIT = 7;

    // =====================================================================
    // Reset values
    localparam logic [7:0] PRIMARY_CONFIG_RST = 8'h04;
    localparam logic [7:0] PRIMARY_FLAGS_RST  = 8'h00;
    localparam logic [7:0] MAX_DUTY_RST       = 8'hFF;
    localparam logic [7:0] FULL_DUTY          = 8'hFF;

    // =====================================================================
    // Timing
    localparam int CLK_PERIOD_NS        = 10;
    localparam int BUS_TIMEOUT_MS       = 35;
    localparam int BUS_TIMEOUT_CYCLES   =
        (BUS_TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;
    localparam int SPINUP_FAN_SPEED_PULSE_PULSES   = 2;
    localparam int SPINUP_TIMEOUT_CYCLES = 4096;

endpackage

// [bench/mcs_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host end of the decoded register port
module mcs_host_model (
    input  wire logic       core_clk_i,
    input  wire logic [7:0] reg_rdata_i,
    output var  logic [7:0] reg_addr_o,
    output var  logic       reg_wr_o,
    output var  logic [7:0] reg_wdata_o,
    output var  logic       reg_rd_o
);
    initial begin
        reg_addr_o  = 8'h00;
        reg_wr_o    = 1'h0;
        reg_wdata_o = 8'h00;
        reg_rd_o    = 1'h0;
    end
    // Released lines invert, so stale values never pass for held ones
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk_i);
        reg_addr_o  = a;
        reg_wdata_o = d;
        reg_wr_o    = 1'h1;
        @(negedge core_clk_i);
        reg_wr_o    = 1'h0;
        reg_addr_o  = ~a;
        reg_wdata_o = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk_i);
        reg_addr_o = a;
        reg_rd_o   = 1'h1;
        @(negedge core_clk_i);
        reg_rd_o   = 1'h0;
        reg_addr_o = ~a;
        @(negedge core_clk_i);
        d = reg_rdata_i;
    endtask
endmodule
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ==========================================
    // Stimulus and observed signals
    logic            core_clk_i      = 1'h0;
    logic            srst_i          = 1'h1;
    logic [7:0]      addr;
    logic            wr_s;
    logic [7:0]      wdata;
    logic            rd_s;
    logic [7:0]      rdata;
    logic            txn             = 1'h0;
    logic            act             = 1'h0;
    logic            rel;
    logic [6:0]      cond            = 7'h00;
    logic            ot_mode         = 1'h0;
    logic            ot_cond         = 1'h0;
    logic [7:0]      sec             = 8'h00;
    logic [7:0]      mask            = 8'hFF;
    logic            alert;
    logic [2:0][7:0] ld              = {8'h30, 8'h20, 8'h10};
    logic [2:0]      sp_start        = 3'h0;
    logic [2:0]      fsp             = 3'h0;
    logic [2:0][7:0] pwm;
    logic [2:0]      sp_act;
    logic            run;
    logic            dflt;
    logic            sense;
    logic [7:0]      v;
    int              mismatches      = 0;
    int              samples_checked = 0;
    int              cycles          = 0;
    int              rel_cnt         = 0;
    int              sp_cnt          = 0;

    // Short counts keep the run small
    mcs_config_status #(.NUM_PWM(3), .TIMEOUT_CYCLES(20),
        .SPINUP_CYCLES(16)) mcs_config_status_i (
        .core_clk_i(core_clk_i), .srst_i(srst_i), .reg_addr_i(addr),
        .reg_wr_i(wr_s), .reg_wdata_i(wdata), .reg_rd_i(rd_s),
        .reg_rdata_o(rdata), .smb_txn_active_i(txn),
        .smb_activity_i(act), .bus_release_o(rel), .limit_cond_i(cond),
        .overtemp_mode_i(ot_mode), .overtemp_timer_cond_i(ot_cond),
        .secondary_status_i(sec), .primary_mask_i(mask),
        .smb_alert_o(alert), .limit_duty_i(ld), .spinup_start_i(sp_start),
        .fan_speed_pulse_i(fsp), .pwm_duty_o(pwm),
        .spinup_active_o(sp_act), .monitor_run_o(run),
        .use_default_limits_o(dflt), .current_sense_flag_o(sense));
    mcs_host_model mcs_host_model_i (
        .core_clk_i(core_clk_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
        .reg_wr_o(wr_s), .reg_wdata_o(wdata), .reg_rd_o(rd_s));

    // ==========================================
    // Clock, watchdog and event counters
    always #5 core_clk_i = ~core_clk_i;
    // Pulses are counted mid-cycle, clear of the launching edge
    always @(negedge core_clk_i) begin
        if (rel === 1'h1) rel_cnt++;
        if (sp_act[0] === 1'h1) sp_cnt++;
    end
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            conclude();
        end
    end

    // ==========================================
    // Helpers
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string n, input logic [7:0] s,
                         input logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        mcs_host_model_i.wr(a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        mcs_host_model_i.rd(a, v);
        check("read", v, e);
    endtask
    // Derived outputs settle two edges after the strobe
    task automatic waitn(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask
    task automatic checkp(input logic [2:0][7:0] e);
        waitn(2);
        for (int g = 0; g < 3; g++) check("pwm", pwm[g], e[g]);
    endtask
    task automatic spin(input logic [7:0] c);
        wr(8'h40, c);
        waitn(2);
        sp_cnt = 0;
        sp_start = 3'h1;
        waitn(1);
        sp_start = 3'h0;
        waitn(2);
        check("spin pwm", pwm[0], 8'hFF);
        repeat (2) begin
            fsp = 3'h1;
            waitn(2);
            fsp = 3'h0;
            waitn(2);
        end
        waitn(20);
    endtask

    // ==========================================
    // Test sequence
    initial begin
        waitn(6);
        srst_i = 1'h0;
        rd(8'h40, mcs_pkg::PRIMARY_CONFIG_RST);
        rd(8'h41, 8'h00);
        rd(8'h38, 8'hFF);
        rd(8'h3B, 8'h00);
        checkp({3{8'hFF}});
        check("dflt", {7'h0, dflt}, 8'h01);
        $display("test reset done");
        wr(8'h40, 8'h01);
        checkp(ld);
        check("dflt", {7'h0, dflt}, 8'h00);
        for (int g = 0; g < 3; g++) wr(8'(8'h38 + g), 8'(8'h80 + g));
        for (int g = 0; g < 3; g++) rd(8'(8'h38 + g), 8'(8'h80 + g));
        wr(8'h40, 8'h09);
        checkp({8'h82, 8'h81, 8'h80});
        wr(8'h40, 8'h00);
        checkp({3{8'hFF}});
        rd(8'h39, 8'h81);
        $display("test run done");
        mask = 8'h00;
        cond = 7'h05;
        waitn(1);
        cond = 7'h00;
        waitn(2);
        check("alert", {7'h0, alert}, 8'h01);
        mask = 8'hFF;
        waitn(2);
        check("alert", {7'h0, alert}, 8'h00);
        rd(8'h41, 8'h05);
        rd(8'h41, 8'h00);
        cond = 7'h70;
        rd(8'h41, 8'h70);
        cond = 7'h00;
        rd(8'h41, 8'h70);
        rd(8'h41, 8'h00);
        ot_mode = 1'h1;
        cond = 7'h01;
        waitn(2);
        cond = 7'h00;
        rd(8'h41, 8'h00);
        ot_cond = 1'h1;
        waitn(2);
        ot_cond = 1'h0;
        rd(8'h41, 8'h01);
        rd(8'h41, 8'h00);
        sec = 8'h02;
        mask = 8'h7F;
        rd(8'h41, 8'h80);
        check("alert", {7'h0, alert}, 8'h01);
        mask = 8'hFF;
        waitn(2);
        check("alert", {7'h0, alert}, 8'h00);
        sec = 8'h00;
        fork
            mcs_host_model_i.rd(8'h41, v);
            begin
                waitn(1);
                cond = 7'h02;
                waitn(1);
                cond = 7'h00;
            end
        join
        check("race read", v, 8'h00);
        rd(8'h41, 8'h02);
        rd(8'h41, 8'h00);
        $display("test flags done");
        rel_cnt = 0;
        wr(8'h40, 8'h40);
        txn = 1'h1;
        waitn(20);
        check("early release", 8'(rel_cnt), 8'h00);
        waitn(10);
        txn = 1'h0;
        check("release", 8'(rel_cnt), 8'h01);
        waitn(1);
        rel_cnt = 0;
        txn = 1'h1;
        waitn(15);
        act = 1'h1;
        waitn(1);
        act = 1'h0;
        waitn(14);
        txn = 1'h0;
        check("act restart", 8'(rel_cnt), 8'h00);
        wr(8'h40, 8'h00);
        rel_cnt = 0;
        txn = 1'h1;
        waitn(30);
        txn = 1'h0;
        check("no release", 8'(rel_cnt), 8'h00);
        $display("test timeout done");
        spin(8'h01);
        check("spin short", 8'(sp_cnt < 14), 8'h01);
        spin(8'h21);
        check("spin full", 8'(sp_cnt), 8'h10);
        $display("test spinup done");
        wr(8'h40, 8'hFF);
        rd(8'h40, 8'h7F);
        check("sense", {7'h0, sense}, 8'h01);
        wr(8'h38, 8'h11);
        rd(8'h38, 8'h80);
        wr(8'h40, 8'h00);
        rd(8'h40, 8'h56);
        wr(8'h40, 8'h01);
        rd(8'h40, 8'h57);
        check("run", {7'h0, run}, 8'h01);
        srst_i = 1'h1;
        waitn(6);
        srst_i = 1'h0;
        rd(8'h40, 8'h04);
        rd(8'h38, 8'hFF);
        checkp({3{8'hFF}});
        check("dflt", {7'h0, dflt}, 8'h01);
        $display("test freeze done");
        conclude();
    end
endmodule
`default_nettype wire
